//--- uart_async_mode_channel.sv
`timescale 1ns/1ps
// ==========================================
// receive fifo
module rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic flush_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out,
  output logic [AW:0] count_out
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_t;
  fifo_t st_r;
  fifo_t st_nxt;
  logic push;
  logic pop;

  assign in_ready_out = st_r.cnt != (AW+1)'(DEPTH);
  assign out_valid_out = st_r.cnt != '0;
  assign out_data_out = st_r.mem[st_r.rp];
  assign count_out = st_r.cnt;

  // pointers wrap naturally, so depth must be a power of two
  always_comb
  begin
    st_nxt = st_r;
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    if (push)
    begin
      st_nxt.mem[st_r.wp] = in_data_in;
      st_nxt.wp = st_r.wp + 1'b1;
    end
    if (pop)
      st_nxt.rp = st_r.rp + 1'b1;
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_in)
    begin
      st_nxt.wp = '0;
      st_nxt.rp = '0;
      st_nxt.cnt = '0;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
endmodule : rx_fifo

// ==========================================
// asynchronous channel
module uart_async_mode_channel #(
  parameter int FIFO_DEPTH = uart_chan_pkg::RX_FIFO_DEPTH,
  parameter int FIFO_AW = uart_chan_pkg::RX_FIFO_AW
) (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] bus_addr_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [1:0] bus_be_in,
  input wire logic [15:0] bus_wdata_in,
  output logic [15:0] bus_rdata_out,
  output logic bus_rvalid_out,
  input wire logic [2:0] serial_mode_field_in,
  input wire logic external_clock_select_in,
  input wire logic stop_two_in,
  input wire logic parity_enable_in,
  input wire logic parity_even_in,
  input wire logic [1:0] count_source_in,
  input wire logic fc_tick_in,
  input wire logic [7:0] bit_rate_divider_in,
  input wire logic open_drain_select_in,
  input wire logic transmit_enable_in,
  input wire logic transmit_enable_wr_in,
  input wire logic receive_enable_in,
  input wire logic tx_pin_select_in,
  input wire logic rx_pin_select_in,
  input wire logic clock_pin_select_in,
  input wire logic rx_port_direction_bit_in,
  input wire logic clk_port_direction_bit_in,
  input wire logic serial_in_pin_in,
  input wire logic transfer_clock_pin_in,
  output logic serial_out_pin_out,
  output logic serial_out_pin_oe_n_out,
  output logic transmit_buffer_empty_flag_out,
  output logic transmit_reg_empty_out,
  output logic receive_complete_flag_out,
  output logic error_sum_out
);
  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] brg;
    logic [2:0] rxs;
    logic [2:0] clks;
    logic rxf;
    logic clkf;
    logic clk_prev;
    uart_chan_pkg::line_state_t tx_st;
    logic [3:0] tph;
    logic [8:0] tb;
    logic tb_full;
    logic halt;
    logic [8:0] tsh;
    logic [3:0] tcnt;
    logic tpar;
    uart_chan_pkg::line_state_t rx_st;
    logic [3:0] rph;
    logic [8:0] rdat;
    logic [3:0] rcnt;
    logic rperr;
    logic rferr;
    logic re_prev;
    logic rx_last;
    logic overrun_error_flag;
    logic so;
    logic so_oe_n;
    logic ti;
    logic txept;
    logic ri;
    logic sum;
    logic [15:0] rdata;
    logic rvalid;
  } core_t;

  core_t st_r;
  core_t n;
  logic x16;
  logic src;
  logic ext_on;
  logic async_on;
  logic rx_line;
  logic tx_end;
  logic samp;
  logic [3:0] nb;
  logic push;
  logic pop;
  logic flush;
  logic [uart_chan_pkg::RX_ENTRY_W-1:0] push_data;
  logic rx_ready;
  logic rx_valid;
  logic [uart_chan_pkg::RX_ENTRY_W-1:0] rx_head;
  logic [FIFO_AW:0] rx_count;

  // data width from mode code
  function automatic logic [3:0] frame_bits(input logic [2:0] m);
    case (m)
      uart_chan_pkg::MODE_A7: frame_bits = 4'h7;
      uart_chan_pkg::MODE_A8: frame_bits = 4'h8;
      default: frame_bits = 4'h9;
    endcase
  endfunction : frame_bits

  function automatic logic is_async(input logic [2:0] m);
    is_async = (m == uart_chan_pkg::MODE_A7) || (m == uart_chan_pkg::MODE_A8)
      || (m == uart_chan_pkg::MODE_A9);
  endfunction : is_async

  // parity over the live payload bits only
  function automatic logic par_calc(input logic [8:0] d, input logic [3:0] w,
    input logic even);
    logic [8:0] m;
    m = (w == 4'h7) ? 9'h07f : (w == 4'h8) ? 9'h0ff : 9'h1ff;
    par_calc = even ? ^(d & m) : ~^(d & m);
  endfunction : par_calc

  rx_fifo #(
    .WIDTH(uart_chan_pkg::RX_ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_rx_fifo (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .flush_in(flush),
    .in_valid_in(push),
    .in_ready_out(rx_ready),
    .in_data_in(push_data),
    .out_valid_out(rx_valid),
    .out_ready_in(pop),
    .out_data_out(rx_head),
    .count_out(rx_count)
  );

  always_comb
  begin
    n = st_r;
    push = 1'b0;
    pop = 1'b0;
    flush = 1'b0;
    x16 = 1'b0;
    src = 1'b0;
    nb = frame_bits(serial_mode_field_in);
    async_on = is_async(serial_mode_field_in);
    // pin filters: a change counts once stages two and three agree
    n.rxs = {st_r.rxs[1:0], serial_in_pin_in};
    n.clks = {st_r.clks[1:0], transfer_clock_pin_in};
    if (st_r.rxs[1] == st_r.rxs[2])
      n.rxf = st_r.rxs[2];
    if (st_r.clks[1] == st_r.clks[2])
      n.clkf = st_r.clks[2];
    n.clk_prev = st_r.clkf;
    ext_on = clock_pin_select_in && external_clock_select_in
      && !clk_port_direction_bit_in;
    rx_line = (rx_pin_select_in && !rx_port_direction_bit_in) ? st_r.rxf : 1'b1;
    // count source, then divide by n+1 to get the 16x tick
    n.pre = st_r.pre + 5'h01;
    if (external_clock_select_in)
      src = ext_on && st_r.clkf && !st_r.clk_prev;
    else
      case (count_source_in)
        2'h0: src = 1'b1;
        2'h1: src = st_r.pre[2:0] == uart_chan_pkg::DIV8_LAST[2:0];
        2'h2: src = st_r.pre == uart_chan_pkg::DIV32_LAST;
        default: src = fc_tick_in;
      endcase
    if (src)
    begin
      if (st_r.brg == 8'h00)
      begin
        n.brg = bit_rate_divider_in;
        x16 = 1'b1;
      end
      else
        n.brg = st_r.brg - 8'h01;
    end
    // ==========================================
    // transmitter
    if (x16)
      n.tph = st_r.tph + 4'h1;
    tx_end = x16 && (st_r.tph == uart_chan_pkg::OVS_LAST);
    case (st_r.tx_st)
      uart_chan_pkg::ST_IDLE:
      begin
        n.so = 1'b1;
        if (async_on && transmit_enable_in && st_r.tb_full && !st_r.halt)
        begin
          n.tsh = st_r.tb;
          n.tb_full = 1'b0;
          n.tpar = par_calc(st_r.tb, nb, parity_even_in);
          n.tph = 4'h0;
          n.so = 1'b0;
          n.tx_st = uart_chan_pkg::ST_START;
        end
      end
      uart_chan_pkg::ST_START:
        if (tx_end)
        begin
          n.tx_st = uart_chan_pkg::ST_DATA;
          n.tcnt = 4'h0;
          n.so = st_r.tsh[0];
        end
      uart_chan_pkg::ST_DATA:
        if (tx_end)
        begin
          if (st_r.tcnt == nb - 4'h1)
          begin
            n.tcnt = 4'h0;
            n.tx_st = parity_enable_in ? uart_chan_pkg::ST_PAR : uart_chan_pkg::ST_STOP;
            n.so = parity_enable_in ? st_r.tpar : 1'b1;
          end
          else
          begin
            n.tcnt = st_r.tcnt + 4'h1;
            n.tsh = st_r.tsh >> 1;
            n.so = st_r.tsh[1];
          end
        end
      uart_chan_pkg::ST_PAR:
        if (tx_end)
        begin
          n.tx_st = uart_chan_pkg::ST_STOP;
          n.so = 1'b1;
        end
      uart_chan_pkg::ST_STOP:
        if (tx_end)
        begin
          if (stop_two_in && st_r.tcnt == 4'h0)
            n.tcnt = 4'h1;
          else
            n.tx_st = uart_chan_pkg::ST_IDLE;
        end
      default: n.tx_st = uart_chan_pkg::ST_IDLE;
    endcase
    // a fresh enable write releases the halt even if enable already reads 1
    if (transmit_enable_wr_in && transmit_enable_in && async_on)
      n.halt = 1'b0;
    // low byte completes the load, so bit 8 must already be there
    if (bus_wr_in && bus_addr_in == uart_chan_pkg::TB_ADDR)
    begin
      if (bus_be_in[1])
        n.tb[8] = bus_wdata_in[8];
      if (bus_be_in[0])
      begin
        n.tb[7:0] = bus_wdata_in[7:0];
        n.tb_full = 1'b1;
      end
    end
    if (serial_mode_field_in == uart_chan_pkg::MODE_OFF)
    begin
      n.tx_st = uart_chan_pkg::ST_IDLE;
      n.tb_full = 1'b0;
      n.halt = 1'b1;
      n.so = 1'b1;
    end
    n.txept = n.tx_st == uart_chan_pkg::ST_IDLE;
    n.ti = !n.tb_full;
    n.so_oe_n = !tx_pin_select_in || (open_drain_select_in && n.so);
    // ==========================================
    // receiver
    n.re_prev = receive_enable_in;
    n.rx_last = rx_line;
    if (x16)
      n.rph = st_r.rph + 4'h1;
    samp = x16 && (st_r.rph == uart_chan_pkg::OVS_MID);
    case (st_r.rx_st)
      uart_chan_pkg::ST_IDLE:
        if (receive_enable_in && async_on && st_r.rx_last && !rx_line)
        begin
          n.rx_st = uart_chan_pkg::ST_START;
          n.rph = 4'h0;
          n.rperr = 1'b0;
          n.rferr = 1'b0;
        end
      uart_chan_pkg::ST_START:
        if (samp)
        begin
          n.rx_st = rx_line ? uart_chan_pkg::ST_IDLE : uart_chan_pkg::ST_DATA;
          n.rcnt = 4'h0;
        end
      uart_chan_pkg::ST_DATA:
        if (samp)
        begin
          n.rdat[st_r.rcnt] = rx_line;
          if (st_r.rcnt == nb - 4'h1)
          begin
            n.rcnt = 4'h0;
            n.rx_st = parity_enable_in ? uart_chan_pkg::ST_PAR : uart_chan_pkg::ST_STOP;
          end
          else
            n.rcnt = st_r.rcnt + 4'h1;
        end
      uart_chan_pkg::ST_PAR:
        if (samp)
        begin
          n.rperr = rx_line != par_calc(st_r.rdat, nb, parity_even_in);
          n.rx_st = uart_chan_pkg::ST_STOP;
        end
      uart_chan_pkg::ST_STOP:
        if (samp)
        begin
          n.rferr = st_r.rferr || !rx_line;
          if (stop_two_in && st_r.rcnt == 4'h0)
            n.rcnt = 4'h1;
          else
          begin
            n.rx_st = uart_chan_pkg::ST_IDLE;
            push = receive_enable_in;
          end
        end
      default: n.rx_st = uart_chan_pkg::ST_IDLE;
    endcase
    push_data = {n.rperr, n.rferr, st_r.rdat};
    // a full fifo drops the frame and flags overrun
    if (push && !rx_ready)
      n.overrun_error_flag = 1'b1;
    if (!receive_enable_in || !async_on)
      n.rx_st = uart_chan_pkg::ST_IDLE;
    if (st_r.re_prev && !receive_enable_in)
    begin
      flush = 1'b1;
      n.overrun_error_flag = 1'b0;
    end
    // ==========================================
    // register reads
    n.rvalid = bus_rd_in;
    n.rdata = 16'h0000;
    if (bus_rd_in && bus_addr_in == uart_chan_pkg::RB_ADDR)
    begin
      n.rdata[8:0] = rx_head[8:0];
      n.rdata[uart_chan_pkg::RB_OER] = st_r.overrun_error_flag;
      n.rdata[uart_chan_pkg::RB_FER] = rx_valid && rx_head[9];
      n.rdata[uart_chan_pkg::RB_PER] = rx_valid && rx_head[10];
      n.rdata[uart_chan_pkg::RB_SUM] = st_r.overrun_error_flag
        || (rx_valid && (rx_head[9] || rx_head[10]));
      pop = bus_be_in[1] && rx_valid;
    end
    n.ri = (rx_valid && !(pop && rx_count == (FIFO_AW+1)'(1)))
      || (push && rx_ready);
    if (flush)
      n.ri = 1'b0;
    n.sum = n.overrun_error_flag || (rx_valid && (rx_head[9] || rx_head[10]));
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      st_r <= '0;
      st_r.so <= 1'b1;
      st_r.so_oe_n <= 1'b1;
      st_r.ti <= 1'b1;
      st_r.txept <= 1'b1;
      st_r.rxs <= 3'h7;
      st_r.rxf <= 1'b1;
      st_r.rx_last <= 1'b1;
    end
    else
      st_r <= n;
  end

  assign bus_rdata_out = st_r.rdata;
  assign bus_rvalid_out = st_r.rvalid;
  assign serial_out_pin_out = st_r.so;
  assign serial_out_pin_oe_n_out = st_r.so_oe_n;
  assign transmit_buffer_empty_flag_out = st_r.ti;
  assign transmit_reg_empty_out = st_r.txept;
  assign receive_complete_flag_out = st_r.ri;
  assign error_sum_out = st_r.sum;

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence s_hi_read;
    bus_rd_in && bus_addr_in == uart_chan_pkg::RB_ADDR && bus_be_in[1];
  endsequence

  AST_IDLE_HIGH: assert property (st_r.tx_st == uart_chan_pkg::ST_IDLE |-> st_r.so)
    else $error("idle line not high");
  AST_OD_FLOAT: assert property ((st_r.so && !st_r.so_oe_n) |-> !$past(open_drain_select_in))
    else $error("open drain drove a high");
  AST_PIN_SEL: assert property (!tx_pin_select_in |=> st_r.so_oe_n)
    else $error("output driven without select");
  AST_RX_SEL: assert property ((!rx_pin_select_in && st_r.rx_st == uart_chan_pkg::ST_IDLE)
    |=> st_r.rx_st == uart_chan_pkg::ST_IDLE)
    else $error("receiver started on deselected pin");
  AST_BIT_EDGE: assert property ((st_r.tx_st == uart_chan_pkg::ST_DATA && $changed(st_r.so))
    |-> $past(st_r.tph) == uart_chan_pkg::OVS_LAST)
    else $error("bit boundary off the 16x phase");
  AST_TX_START: assert property ((st_r.tx_st == uart_chan_pkg::ST_START
    && $past(st_r.tx_st) == uart_chan_pkg::ST_IDLE)
    |-> $past(transmit_enable_in && st_r.tb_full && !st_r.halt))
    else $error("frame started without enable or data");
  AST_OFF_FLUSH: assert property (serial_mode_field_in == uart_chan_pkg::MODE_OFF
    |=> st_r.tx_st == uart_chan_pkg::ST_IDLE && !st_r.tb_full && st_r.so && st_r.halt)
    else $error("mode off did not empty transmitter");
  AST_RE_RESET: assert property ($fell(receive_enable_in)
    |=> !rx_valid && !st_r.ri && !st_r.overrun_error_flag)
    else $error("receive reset incomplete");
  AST_HI_READ: assert property ((s_hi_read ##0 (rx_count == (FIFO_AW+1)'(1) && !push))
    |=> !rx_valid && !st_r.ri)
    else $error("high byte read did not clear complete");
  AST_OVERRUN: assert property ((push && !rx_ready) |=> st_r.overrun_error_flag && st_r.sum)
    else $error("overrun not flagged");
endmodule : uart_async_mode_channel

//--- uart_chan_pkg.sv
package uart_chan_pkg;
  // ==========================================
  // register map and fields
  localparam logic [15:0] TB_ADDR = 16'h00a2;
  localparam logic [15:0] RB_ADDR = 16'h00a6;
  localparam int RB_OER = 12;
  localparam int RB_FER = 13;
  localparam int RB_PER = 14;
  localparam int RB_SUM = 15;
  // ==========================================
  // mode codes
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [2:0] MODE_A7 = 3'h4;
  localparam logic [2:0] MODE_A8 = 3'h5;
  localparam logic [2:0] MODE_A9 = 3'h6;
  // ==========================================
  // timing counts
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [4:0] DIV8_LAST = 5'h07;
  localparam logic [4:0] DIV32_LAST = 5'h1f;
  localparam int RX_FIFO_DEPTH = 32;
  localparam int RX_FIFO_AW = 5;
  localparam int RX_ENTRY_W = 11;
  // ==========================================
  // frame sequencer states, gray along the path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START = 3'h1,
    ST_DATA = 3'h3,
    ST_PAR = 3'h2,
    ST_STOP = 3'h6
  } line_state_t;
endpackage : uart_chan_pkg

//--- uart_remote_model.sv
`timescale 1ns/1ps
// ==========================================
// far-end transceiver on the serial lines
module uart_remote_model (
  input wire logic core_clk_in,
  input wire logic [11:0] bit_cyc_in,
  input wire logic line_in,
  output logic line_out = 1'b1
);
  int bit_cyc;
  // bit length in clocks comes from the bench; the line idles high between frames
  assign bit_cyc = int'(bit_cyc_in);
  // start, lsb first, one stop; a low stop forces a framing fault
  task automatic send(input logic [8:0] d, input int nb, input logic bad);
    line_out <= 1'b0;
    repeat (bit_cyc) @(posedge core_clk_in);
    for (int i = 0; i < nb; i++)
    begin
      line_out <= d[i];
      repeat (bit_cyc) @(posedge core_clk_in);
    end
    line_out <= ~bad;
    repeat (bit_cyc) @(posedge core_clk_in);
    line_out <= 1'b1;
    repeat (bit_cyc) @(posedge core_clk_in);
  endtask : send
  // mid-bit sampling; ok drops on a missing start or stop
  task automatic recv(input int nb, output logic [8:0] d, output logic ok);
    int n;
    d = 9'h000;
    n = 0;
    while (line_in !== 1'b0 && n < 4000)
    begin
      @(posedge core_clk_in);
      n++;
    end
    repeat (bit_cyc / 2) @(posedge core_clk_in);
    ok = (line_in === 1'b0);
    for (int i = 0; i < nb; i++)
    begin
      repeat (bit_cyc) @(posedge core_clk_in);
      d[i] = line_in;
    end
    repeat (bit_cyc) @(posedge core_clk_in);
    ok = ok & (line_in === 1'b1);
  endtask : recv
endmodule : uart_remote_model

//--- uart_async_mode_channel_tb_top.sv
`timescale 1ns/1ps
// ==========================================
// bench top
module uart_async_mode_channel_tb_top;
  localparam logic [15:0] TB = uart_chan_pkg::TB_ADDR;
  localparam logic [15:0] RB = uart_chan_pkg::RB_ADDR;
  logic core_clk_in, sys_rst_in, bus_wr_in, bus_rd_in, bus_rvalid_out;
  logic [15:0] bus_addr_in, bus_wdata_in, bus_rdata_out, rd, mask;
  logic [1:0] bus_be_in, count_source_in;
  logic [2:0] serial_mode_field_in, div_r;
  logic [7:0] bit_rate_divider_in;
  logic external_clock_select_in, stop_two_in, parity_enable_in, parity_even_in;
  logic fc_tick_in, open_drain_select_in, transmit_enable_in, transmit_enable_wr_in;
  logic receive_enable_in, tx_pin_select_in, rx_pin_select_in, clock_pin_select_in;
  logic rx_port_direction_bit_in, clk_port_direction_bit_in, serial_in_pin_in;
  logic transfer_clock_pin_in, serial_out_pin_out, serial_out_pin_oe_n_out;
  logic transmit_buffer_empty_flag_out, transmit_reg_empty_out;
  logic receive_complete_flag_out, error_sum_out, ok;
  logic [8:0] rx;
  logic [11:0] bit_cyc;
  int error_cnt, checked;
  int r_src[5] = '{0, 1, 2, 3, 0};
  int r_n[5] = '{2, 0, 0, 0, 0};
  int r_bit[5] = '{48, 128, 512, 128, 128};
  logic [2:0] modes[3] = '{uart_chan_pkg::MODE_A7, uart_chan_pkg::MODE_A8,
                           uart_chan_pkg::MODE_A9};
  logic [8:0] e_d[4] = '{9'h03c, 9'h001, 9'h101, 9'h001};
  logic [15:0] e_x[4] = '{16'ha03c, 16'hc001, 16'h0001, 16'h0001};

  uart_async_mode_channel u_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .bus_addr_in(bus_addr_in),
    .bus_wr_in(bus_wr_in), .bus_rd_in(bus_rd_in), .bus_be_in(bus_be_in),
    .bus_wdata_in(bus_wdata_in), .bus_rdata_out(bus_rdata_out),
    .bus_rvalid_out(bus_rvalid_out), .serial_mode_field_in(serial_mode_field_in),
    .external_clock_select_in(external_clock_select_in), .stop_two_in(stop_two_in),
    .parity_enable_in(parity_enable_in), .parity_even_in(parity_even_in),
    .count_source_in(count_source_in), .fc_tick_in(fc_tick_in),
    .bit_rate_divider_in(bit_rate_divider_in), .open_drain_select_in(open_drain_select_in),
    .transmit_enable_in(transmit_enable_in), .transmit_enable_wr_in(transmit_enable_wr_in),
    .receive_enable_in(receive_enable_in), .tx_pin_select_in(tx_pin_select_in),
    .rx_pin_select_in(rx_pin_select_in), .clock_pin_select_in(clock_pin_select_in),
    .rx_port_direction_bit_in(rx_port_direction_bit_in),
    .clk_port_direction_bit_in(clk_port_direction_bit_in),
    .serial_in_pin_in(serial_in_pin_in), .transfer_clock_pin_in(transfer_clock_pin_in),
    .serial_out_pin_out(serial_out_pin_out), .serial_out_pin_oe_n_out(serial_out_pin_oe_n_out),
    .transmit_buffer_empty_flag_out(transmit_buffer_empty_flag_out),
    .transmit_reg_empty_out(transmit_reg_empty_out),
    .receive_complete_flag_out(receive_complete_flag_out), .error_sum_out(error_sum_out)
  );
  uart_remote_model u_remote (
    .core_clk_in(core_clk_in),
    .bit_cyc_in(bit_cyc),
    .line_in(serial_out_pin_out),
    .line_out(serial_in_pin_in)
  );

  // ==========================================
  // clock and slow sources
  initial
  begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  // sub clock pulse and pin clock both every 8 cycles
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      div_r <= 3'h0;
    else
      div_r <= div_r + 3'h1;
    fc_tick_in <= (div_r == 3'h7);
    transfer_clock_pin_in <= div_r[2];
  end

  // ==========================================
  // access and compare tasks
  task automatic print_verdict();
    if (error_cnt == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic bus_wr(input logic [15:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge core_clk_in);
    bus_addr_in <= a;
    bus_be_in <= be;
    bus_wdata_in <= d;
    bus_wr_in <= 1'b1;
    @(posedge core_clk_in);
    bus_wr_in <= 1'b0;
  endtask : bus_wr
  // always a full 16-bit read, so the fifo head is popped
  task automatic bus_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge core_clk_in);
    bus_addr_in <= a;
    bus_be_in <= 2'b11;
    bus_rd_in <= 1'b1;
    @(posedge core_clk_in);
    bus_rd_in <= 1'b0;
    #1;
    chk("rvalid", 16'h0001, bus_rvalid_out);
    d = bus_rdata_out;
  endtask : bus_rd
  task automatic wait_rx();
    int n;
    n = 0;
    while (receive_complete_flag_out !== 1'b1)
    begin
      @(posedge core_clk_in);
      #1;
      n++;
      if (n > 2000)
      begin
        error_cnt++;
        $display("[FAIL] rx flag expected 1 seen 0");
        print_verdict();
      end
    end
  endtask : wait_rx

  // ==========================================
  // main sequence
  initial
  begin
    {bus_wr_in, bus_rd_in, bus_addr_in, bus_wdata_in, bus_be_in} = '0;
    {count_source_in, bit_rate_divider_in, external_clock_select_in} = '0;
    {stop_two_in, parity_enable_in, parity_even_in, open_drain_select_in} = '0;
    transmit_enable_wr_in = 1'b0;
    bit_cyc = 12'h010;
    {rx_port_direction_bit_in, clk_port_direction_bit_in} = '0;
    {transmit_enable_in, receive_enable_in, tx_pin_select_in} = 3'h7;
    {rx_pin_select_in, clock_pin_select_in} = 2'h3;
    serial_mode_field_in = uart_chan_pkg::MODE_A8;
    sys_rst_in = 1'b1;
    repeat (10) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("idle line", 16'h0001, serial_out_pin_out);
    chk("idle oe_n", 16'h0000, serial_out_pin_oe_n_out);
    chk("tx empty", 16'h0001, transmit_buffer_empty_flag_out);
    @(posedge core_clk_in);
    tx_pin_select_in <= 1'b0;
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("port oe_n", 16'h0001, serial_out_pin_oe_n_out);
    @(posedge core_clk_in);
    tx_pin_select_in <= 1'b1;
    open_drain_select_in <= 1'b1;
    repeat (3) @(posedge core_clk_in);
    #1;
    chk("float oe_n", 16'h0001, serial_out_pin_oe_n_out);
    @(posedge core_clk_in);
    open_drain_select_in <= 1'b0;
    // every count source, a divider above zero, and the pin clock
    for (int k = 0; k < 5; k++)
    begin
      @(posedge core_clk_in);
      count_source_in <= 2'(r_src[k]);
      bit_rate_divider_in <= 8'(r_n[k]);
      external_clock_select_in <= (k == 4);
      bit_cyc <= 12'(r_bit[k]);
      fork
        bus_wr(TB, 2'b01, 16'h00c5 + 16'(k));
        u_remote.recv(8, rx, ok);
      join
      chk("rate byte", 16'h00c5 + 16'(k), {7'h00, rx});
      chk("rate frame", 16'h0001, ok);
    end
    @(posedge core_clk_in);
    {count_source_in, bit_rate_divider_in, external_clock_select_in} <= '0;
    bit_cyc <= 12'h010;
    // each frame width both ways; unused receive bits masked off
    for (int k = 0; k < 3; k++)
    begin
      @(posedge core_clk_in);
      serial_mode_field_in <= modes[k];
      mask = 16'h01ff >> (2 - k);
      fork
        begin
          bus_wr(TB, 2'b10, 16'h0100);
          bus_wr(TB, 2'b01, 16'h00b6);
        end
        u_remote.recv(7 + k, rx, ok);
      join
      chk("tx word", 16'h01b6 & mask, {7'h00, rx});
      u_remote.send(9'h1d3, 7 + k, 1'b0);
      wait_rx();
      bus_rd(RB, rd);
      chk("rx word", 16'h01d3 & mask, rd & (mask | 16'hf000));
      chk("rx flag clr", 16'h0000, receive_complete_flag_out);
    end
    // framing fault, bad even parity, good even and odd parity
    for (int k = 0; k < 4; k++)
    begin
      @(posedge core_clk_in);
      serial_mode_field_in <= uart_chan_pkg::MODE_A8;
      parity_enable_in <= (k > 0);
      parity_even_in <= (k < 3);
      u_remote.send(e_d[k], (k > 0) ? 9 : 8, (k == 0));
      wait_rx();
      @(posedge core_clk_in);
      #1;
      chk("err sum", 16'(e_x[k][15]), error_sum_out);
      bus_rd(RB, rd);
      chk("err word", e_x[k], rd & 16'hf0ff);
      // error sum follows the new head one clock after the pop
      @(posedge core_clk_in);
      #1;
      chk("err clr", 16'h0000, {receive_complete_flag_out, error_sum_out});
    end
    @(posedge core_clk_in);
    parity_enable_in <= 1'b0;
    // overfill the fifo by one, drain it, then reset the receiver
    for (int k = 0; k < 33; k++)
      u_remote.send(9'(k), 8, 1'b0);
    #1;
    chk("ovr sum", 16'h0001, error_sum_out);
    for (int k = 0; k < 32; k++)
    begin
      bus_rd(RB, rd);
      chk("fifo word", 16'h9000 | 16'(k), rd & 16'hf0ff);
    end
    chk("fifo empty", 16'h0000, receive_complete_flag_out);
    u_remote.send(9'h011, 8, 1'b0);
    wait_rx();
    @(posedge core_clk_in);
    receive_enable_in <= 1'b0;
    @(posedge core_clk_in);
    receive_enable_in <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    chk("rx reset", 16'h0000, {receive_complete_flag_out, error_sum_out});
    // abort mid-frame, stay halted, resume on the enable rewrite
    bus_wr(TB, 2'b01, 16'h0055);
    repeat (40) @(posedge core_clk_in);
    serial_mode_field_in <= uart_chan_pkg::MODE_OFF;
    repeat (4) @(posedge core_clk_in);
    #1;
    chk("abort line", 16'h0001, serial_out_pin_out);
    chk("abort empty", 16'h0001, transmit_buffer_empty_flag_out);
    @(posedge core_clk_in);
    serial_mode_field_in <= uart_chan_pkg::MODE_A8;
    bus_wr(TB, 2'b01, 16'h0066);
    repeat (60) @(posedge core_clk_in);
    #1;
    chk("halt line", 16'h0001, serial_out_pin_out);
    chk("halt full", 16'h0000, transmit_buffer_empty_flag_out);
    @(posedge core_clk_in);
    transmit_enable_wr_in <= 1'b1;
    stop_two_in <= 1'b1;
    fork
      @(posedge core_clk_in) transmit_enable_wr_in <= 1'b0;
      u_remote.recv(8, rx, ok);
    join
    chk("resume byte", 16'h0066, {7'h00, rx});
    chk("done empty", 16'h0001, transmit_buffer_empty_flag_out);
    // recv returns mid first stop; one bit on, the second stop still runs
    repeat (16) @(posedge core_clk_in);
    #1;
    chk("two stop busy", 16'h0000, transmit_reg_empty_out);
    repeat (16) @(posedge core_clk_in);
    #1;
    chk("tx reg idle", 16'h0001, transmit_reg_empty_out);
    // input unused when deselected or the pin is an output
    for (int k = 0; k < 2; k++)
    begin
      @(posedge core_clk_in);
      rx_pin_select_in <= k[0];
      rx_port_direction_bit_in <= k[0];
      repeat (4) @(posedge core_clk_in);
      u_remote.send(9'h05a, 8, 1'b0);
      #1;
      chk("pin off rx", 16'h0000, receive_complete_flag_out);
    end
    bus_rd(16'h00a4, rd);
    chk("unmapped", 16'h0000, rd);
    print_verdict();
  end
endmodule : uart_async_mode_channel_tb_top
